// >>> shared/icm_pkg.sv
// Function
// - decode memory command codes 96h 44h C3h AAh
// - decode configuration codes 75h 52h 99h 62h
// - recognise bus codes 88h ABh 50h 68h
// - 11h search, 57h sequence, CCh CRC16
// - block commands ABh, 68h: optional reset, optional strong pullup
// - host frames code, length, parameters, data, stop
// - host waits processing time before read-back
// - read-back returns length, result, then data
// - result AAh success, anything else error
// - host reads data after result, then stops
// - page write is 32 bytes, pages 0-5
// - protected or odd page: unchanged, result 55h
// - invalid page-write input gives result 77h
// - write parameter page in bits 2:0, rest zero
// - write length 33; reply length 1, result
// - check protection, store data, set result
// - page read returns all 32 bytes, AAh
// - invalid page read: 32 FFh bytes, 77h
// - odd page read succeeds, content not fixed
// - read parameter page bits 2:0, pages 0-5
// - read length 1; reply length 33, result, data
package icm_pkg;
  localparam logic [7:0] CMD_WRITE_MEM = 8'h96;
  localparam logic [7:0] CMD_READ_MEM = 8'h44;
  localparam logic [7:0] CMD_SET_PROT = 8'hC3;
  localparam logic [7:0] CMD_READ_STAT = 8'hAA;
  localparam logic [7:0] CMD_SET_ADDR = 8'h75;
  localparam logic [7:0] CMD_RD_PORT = 8'h52;
  localparam logic [7:0] CMD_WR_PORT = 8'h99;
  localparam logic [7:0] CMD_MASTER_RST = 8'h62;
  localparam logic [7:0] CMD_SCRIPT = 8'h88;
  localparam logic [7:0] CMD_BLOCK = 8'hAB;
  localparam logic [7:0] CMD_RD_BLOCK = 8'h50;
  localparam logic [7:0] CMD_WR_BLOCK = 8'h68;
  localparam logic [7:0] CMD_SEARCH = 8'h11;
  localparam logic [7:0] CMD_FULL_SEQ = 8'h57;
  localparam logic [7:0] CMD_CRC16 = 8'hCC;
  localparam logic [7:0] RES_OK = 8'hAA;
  localparam logic [7:0] RES_PROT = 8'h55;
  localparam logic [7:0] RES_INVALID = 8'h77;
  localparam logic [7:0] FILL_INVALID = 8'hFF;
  localparam int PAGE_BYTES = 32;
  localparam int NUM_PAGES = 6;
  localparam int PAGE_LSB = 0;
  localparam int PAGE_MSB = 2;
  localparam logic [7:0] LEN_WRITE_MEM = 8'h21;
  localparam logic [7:0] LEN_READ_MEM = 8'h01;
  localparam logic [7:0] RSP_LEN_SHORT = 8'h01;
  localparam logic [7:0] RSP_LEN_READ = 8'h21;
  localparam logic [7:0] RSP_HDR_BYTES = 8'h02;
  localparam int OPT_RESET_BIT = 0;
  localparam int OPT_SPU_BIT = 1;
  localparam logic [5:0] PROT_INIT = 6'h2A; // odd pages locked
  localparam int CLK_MHZ = 50;
  localparam int WRITE_MEMORY_TIME_US = 100;
  localparam int READ_MEMORY_TIME_US = 50;
  localparam int WRITE_MEMORY_CYCLES = WRITE_MEMORY_TIME_US * CLK_MHZ;
  localparam int READ_MEMORY_CYCLES = READ_MEMORY_TIME_US * CLK_MHZ;
  typedef enum logic [2:0] {
    ICM_CLS_NONE, ICM_CLS_MEMORY, ICM_CLS_CONFIG, ICM_CLS_BUS, ICM_CLS_CRC
  } icm_class_e;
endpackage

// >>> shared/icm_link_if.sv
`timescale 1ns/100ps
`default_nettype none
// byte-level view of the serial command bus between the two ends
interface icm_link_if;
  logic wr_start;
  logic wr_valid;
  logic wr_ready;
  logic [7:0] wr_data;
  logic wr_stop;
  logic rd_start;
  logic rd_req;
  logic rd_valid;
  logic [7:0] rd_data;
  logic rd_stop;
  modport host (output wr_start, wr_valid, wr_data, wr_stop, rd_start,
                rd_req, rd_stop, input wr_ready, rd_valid, rd_data);
  modport dev (input wr_start, wr_valid, wr_data, wr_stop, rd_start,
               rd_req, rd_stop, output wr_ready, rd_valid, rd_data);
endinterface
`default_nettype wire

// >>> core/icm_host.sv
`timescale 1ns/100ps
`default_nettype none
module icm_host #(
  parameter int WRITE_WAIT_CYCLES = icm_pkg::WRITE_MEMORY_CYCLES,
  parameter int READ_WAIT_CYCLES = icm_pkg::READ_MEMORY_CYCLES
) (
  input wire logic clk_sys_i, // system clock
  input wire logic rstn_i, // async reset, active low
  icm_link_if.host link, // link to the device
  input wire logic cmd_valid_i, // start a command
  output logic cmd_ready_o, // idle, command accepted
  input wire logic [7:0] cmd_code_i, // command code
  input wire logic [7:0] wr_len_i, // write length byte
  input wire logic [7:0] param_i, // first parameter byte
  input wire logic dat_valid_i, // data byte offered
  input wire logic [7:0] dat_i, // data byte
  output logic dat_ready_o, // data byte taken
  output logic rsp_valid_o, // response data byte pulse
  output logic [7:0] rsp_data_o, // response data byte
  output logic done_o, // read-back finished pulse
  output logic [7:0] result_o, // result byte
  output logic [7:0] rsp_len_o // length byte
);
  typedef enum {H_IDLE, H_START, H_SEND, H_STOP, H_WAIT, H_RSTART, H_REQ,
                H_RWAIT, H_RSTOP} icm_host_state_e;
  icm_host_state_e state_r, state_nxt;
  logic [7:0] code_r, code_nxt, len_r, len_nxt, param_r, param_nxt;
  logic [8:0] bcnt_r, bcnt_nxt;
  logic tx_full_r, tx_full_nxt;
  logic [7:0] tx_byte_r, tx_byte_nxt;
  logic [31:0] wait_r, wait_nxt;
  logic [7:0] ridx_r, ridx_nxt, rlen_r, rlen_nxt, res_r, res_nxt;
  logic rsp_valid_r, rsp_valid_nxt, done_r, done_nxt;
  logic [7:0] rsp_data_r, rsp_data_nxt;
  logic [8:0] total;
  logic can_load;

  // frame holds code and length ahead of the body
  assign total = 9'(len_r) + 9'h002;
  assign can_load = (!tx_full_r || link.wr_ready) && (bcnt_r < total);
  assign dat_ready_o = (state_r == H_SEND) && can_load && (bcnt_r > 9'h002)
    && dat_valid_i;
  assign cmd_ready_o = (state_r == H_IDLE);
  assign link.wr_start = (state_r == H_START);
  assign link.wr_valid = tx_full_r;
  assign link.wr_data = tx_byte_r;
  assign link.wr_stop = (state_r == H_STOP);
  assign link.rd_start = (state_r == H_RSTART);
  assign link.rd_req = (state_r == H_REQ);
  assign link.rd_stop = (state_r == H_RSTOP);
  assign rsp_valid_o = rsp_valid_r;
  assign rsp_data_o = rsp_data_r;
  assign done_o = done_r;
  assign result_o = res_r;
  assign rsp_len_o = rlen_r;

  // sequencer next state
  always_comb
  begin
    state_nxt = state_r;
    code_nxt = code_r;
    len_nxt = len_r;
    param_nxt = param_r;
    bcnt_nxt = bcnt_r;
    tx_full_nxt = tx_full_r;
    tx_byte_nxt = tx_byte_r;
    wait_nxt = wait_r;
    ridx_nxt = ridx_r;
    rlen_nxt = rlen_r;
    res_nxt = res_r;
    rsp_valid_nxt = 1'b0;
    rsp_data_nxt = rsp_data_r;
    done_nxt = 1'b0;
    case (state_r)
      H_IDLE:
        if (cmd_valid_i)
        begin
          code_nxt = cmd_code_i;
          len_nxt = wr_len_i;
          param_nxt = param_i;
          bcnt_nxt = 9'h000;
          state_nxt = H_START;
        end
      H_START:
        state_nxt = H_SEND;
      H_SEND:
      begin
        if (tx_full_r && link.wr_ready)
          tx_full_nxt = 1'b0;
        // code, length, parameter, then user data, in that order
        if (can_load && (bcnt_r <= 9'h002 || dat_valid_i))
        begin
          tx_full_nxt = 1'b1;
          bcnt_nxt = bcnt_r + 9'h001;
          if (bcnt_r == 9'h000)
            tx_byte_nxt = code_r;
          else if (bcnt_r == 9'h001)
            tx_byte_nxt = len_r;
          else if (bcnt_r == 9'h002)
            tx_byte_nxt = param_r;
          else
            tx_byte_nxt = dat_i;
        end
        else if (bcnt_r >= total && !tx_full_nxt)
          state_nxt = H_STOP;
      end
      H_STOP:
      begin
        state_nxt = H_WAIT;
        wait_nxt = (code_r == icm_pkg::CMD_WRITE_MEM) ?
          32'(WRITE_WAIT_CYCLES) : 32'(READ_WAIT_CYCLES);
      end
      H_WAIT:
        if (wait_r <= 32'h1)
          state_nxt = H_RSTART;
        else
          wait_nxt = wait_r - 32'h1;
      H_RSTART:
      begin
        ridx_nxt = 8'h00;
        state_nxt = H_REQ;
      end
      H_REQ:
        state_nxt = H_RWAIT;
      H_RWAIT:
        if (link.rd_valid)
        begin
          ridx_nxt = ridx_r + 8'h01;
          if (ridx_r == 8'h00)
            rlen_nxt = link.rd_data;
          else if (ridx_r == 8'h01)
            res_nxt = link.rd_data;
          else
          begin
            rsp_valid_nxt = 1'b1;
            rsp_data_nxt = link.rd_data;
          end
          // length counts the bytes after itself
          if ((ridx_r == 8'h00 && link.rd_data == 8'h00) ||
              (ridx_r != 8'h00 && ridx_r >= rlen_r))
            state_nxt = H_RSTOP;
          else
            state_nxt = H_REQ;
        end
      H_RSTOP:
      begin
        done_nxt = 1'b1;
        state_nxt = H_IDLE;
      end
      default:
        state_nxt = H_IDLE;
    endcase
  end

  // sequencer registers
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_r <= H_IDLE;
      code_r <= 8'h00;
      len_r <= 8'h00;
      param_r <= 8'h00;
      bcnt_r <= 9'h000;
      tx_full_r <= 1'b0;
      tx_byte_r <= 8'h00;
      wait_r <= 32'h0;
      ridx_r <= 8'h00;
      rlen_r <= 8'h00;
      res_r <= 8'h00;
      rsp_valid_r <= 1'b0;
      rsp_data_r <= 8'h00;
      done_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      code_r <= code_nxt;
      len_r <= len_nxt;
      param_r <= param_nxt;
      bcnt_r <= bcnt_nxt;
      tx_full_r <= tx_full_nxt;
      tx_byte_r <= tx_byte_nxt;
      wait_r <= wait_nxt;
      ridx_r <= ridx_nxt;
      rlen_r <= rlen_nxt;
      res_r <= res_nxt;
      rsp_valid_r <= rsp_valid_nxt;
      rsp_data_r <= rsp_data_nxt;
      done_r <= done_nxt;
    end
  end
endmodule
`default_nettype wire

// >>> core/icm_dev.sv
`timescale 1ns/100ps
`default_nettype none
module icm_dev (
  input wire logic clk_sys_i, // system clock
  input wire logic rstn_i, // async reset, active low
  icm_link_if.dev link, // link to the host
  output icm_pkg::icm_class_e cmd_class_o, // class of last command
  output logic [7:0] cmd_code_o, // last command code
  output logic cmd_exec_o, // command executed pulse
  output logic bus_reset_o, // bus reset request pulse
  output logic strong_pullup_o, // strong pullup request pulse
  output logic busy_o // frame or execution in progress
);
  typedef enum {D_IDLE, D_CMD, D_LEN, D_BODY, D_EXEC, D_READY,
                D_RESP} icm_dev_state_e;
  localparam int MEM_BYTES = icm_pkg::PAGE_BYTES * icm_pkg::NUM_PAGES;

  icm_dev_state_e state_r, state_nxt;
  logic [7:0] code_r, code_nxt, len_r, len_nxt, param_r, param_nxt;
  logic [7:0] cnt_r, cnt_nxt, idx_r, idx_nxt;
  logic [7:0] rsp_len_r, rsp_len_nxt, result_r, result_nxt;
  logic [7:0] rd_data_r, rd_data_nxt;
  logic rd_valid_r, rd_valid_nxt, rd_ok_r, rd_ok_nxt;
  logic exec_r, exec_nxt, brst_r, brst_nxt, spu_r, spu_nxt;
  icm_pkg::icm_class_e class_r, class_nxt;
  logic commit;
  logic param_ok;
  logic [2:0] page;
  logic [7:0] data_off;
  logic [7:0] mem [0:MEM_BYTES-1];
  logic [7:0] wbuf [0:icm_pkg::PAGE_BYTES-1];

  // command class from the code table
  function automatic icm_pkg::icm_class_e classify(input logic [7:0] c);
    case (c)
      icm_pkg::CMD_WRITE_MEM, icm_pkg::CMD_READ_MEM,
      icm_pkg::CMD_SET_PROT, icm_pkg::CMD_READ_STAT:
        classify = icm_pkg::ICM_CLS_MEMORY;
      icm_pkg::CMD_SET_ADDR, icm_pkg::CMD_RD_PORT,
      icm_pkg::CMD_WR_PORT, icm_pkg::CMD_MASTER_RST:
        classify = icm_pkg::ICM_CLS_CONFIG;
      icm_pkg::CMD_SCRIPT, icm_pkg::CMD_BLOCK, icm_pkg::CMD_RD_BLOCK,
      icm_pkg::CMD_WR_BLOCK, icm_pkg::CMD_SEARCH, icm_pkg::CMD_FULL_SEQ:
        classify = icm_pkg::ICM_CLS_BUS;
      icm_pkg::CMD_CRC16:
        classify = icm_pkg::ICM_CLS_CRC;
      default:
        classify = icm_pkg::ICM_CLS_NONE;
    endcase
  endfunction

  // page field and reserved-bit check
  assign page = param_r[icm_pkg::PAGE_MSB:icm_pkg::PAGE_LSB];
  assign param_ok = (param_r[7:icm_pkg::PAGE_MSB+1] == '0) &&
    (32'(page) < icm_pkg::NUM_PAGES);
  assign data_off = idx_r - icm_pkg::RSP_HDR_BYTES;
  assign link.wr_ready = (state_r == D_CMD) || (state_r == D_LEN) ||
    (state_r == D_BODY);
  assign link.rd_valid = rd_valid_r;
  assign link.rd_data = rd_data_r;
  assign cmd_class_o = class_r;
  assign cmd_code_o = code_r;
  assign cmd_exec_o = exec_r;
  assign bus_reset_o = brst_r;
  assign strong_pullup_o = spu_r;
  assign busy_o = (state_r != D_IDLE) && (state_r != D_READY) &&
    (state_r != D_RESP);

  // command sequencer next state
  always_comb
  begin
    state_nxt = state_r;
    code_nxt = code_r;
    len_nxt = len_r;
    param_nxt = param_r;
    cnt_nxt = cnt_r;
    idx_nxt = idx_r;
    rsp_len_nxt = rsp_len_r;
    result_nxt = result_r;
    rd_data_nxt = rd_data_r;
    rd_ok_nxt = rd_ok_r;
    class_nxt = class_r;
    rd_valid_nxt = 1'b0;
    exec_nxt = 1'b0;
    brst_nxt = 1'b0;
    spu_nxt = 1'b0;
    commit = 1'b0;
    case (state_r)
      D_IDLE, D_READY:
        ;
      D_CMD:
        if (link.wr_valid)
        begin
          code_nxt = link.wr_data;
          state_nxt = D_LEN;
        end
        else if (link.wr_stop)
          state_nxt = D_IDLE;
      D_LEN:
        if (link.wr_valid)
        begin
          len_nxt = link.wr_data;
          cnt_nxt = 8'h00;
          state_nxt = D_BODY;
        end
        else if (link.wr_stop)
          state_nxt = D_IDLE;
      D_BODY:
      begin
        if (link.wr_valid && cnt_r == 8'h00)
          param_nxt = link.wr_data;
        // saturate so a runaway frame cannot wrap to a legal count
        if (link.wr_valid && cnt_r != 8'hFF)
          cnt_nxt = cnt_r + 8'h01;
        if (link.wr_stop)
          state_nxt = D_EXEC;
      end
      D_EXEC:
      begin
        exec_nxt = 1'b1;
        class_nxt = classify(code_r);
        rsp_len_nxt = icm_pkg::RSP_LEN_SHORT;
        rd_ok_nxt = 1'b0;
        state_nxt = D_READY;
        case (code_r)
          icm_pkg::CMD_WRITE_MEM:
            // validate, then protection, then store, then result
            if (len_r != icm_pkg::LEN_WRITE_MEM ||
                cnt_r != icm_pkg::LEN_WRITE_MEM || !param_ok)
              result_nxt = icm_pkg::RES_INVALID;
            else if (icm_pkg::PROT_INIT[page])
              result_nxt = icm_pkg::RES_PROT;
            else
            begin
              commit = 1'b1;
              result_nxt = icm_pkg::RES_OK;
            end
          icm_pkg::CMD_READ_MEM:
          begin
            rsp_len_nxt = icm_pkg::RSP_LEN_READ;
            if (len_r == icm_pkg::LEN_READ_MEM &&
                cnt_r == icm_pkg::LEN_READ_MEM && param_ok)
            begin
              rd_ok_nxt = 1'b1;
              result_nxt = icm_pkg::RES_OK;
            end
            else
              result_nxt = icm_pkg::RES_INVALID;
          end
          icm_pkg::CMD_BLOCK, icm_pkg::CMD_WR_BLOCK:
          begin
            // hand the option bits to the bus engine
            brst_nxt = param_r[icm_pkg::OPT_RESET_BIT];
            spu_nxt = param_r[icm_pkg::OPT_SPU_BIT];
            result_nxt = icm_pkg::RES_OK;
          end
          default:
            result_nxt = icm_pkg::RES_INVALID;
        endcase
      end
      D_RESP:
        if (link.rd_req)
        begin
          rd_valid_nxt = 1'b1;
          idx_nxt = idx_r + 8'h01;
          if (idx_r == 8'h00)
            rd_data_nxt = rsp_len_r;
          else if (idx_r == 8'h01)
            rd_data_nxt = result_r;
          else if (rd_ok_r && 32'(data_off) < icm_pkg::PAGE_BYTES)
            rd_data_nxt = mem[8'(32'(page) * icm_pkg::PAGE_BYTES) +
              data_off];
          else
            rd_data_nxt = icm_pkg::FILL_INVALID;
        end
      default:
        state_nxt = D_IDLE;
    endcase
    // a new frame always restarts the parser
    if (link.wr_start)
      state_nxt = D_CMD;
    else if (link.rd_start && (state_r == D_READY || state_r == D_RESP))
    begin
      state_nxt = D_RESP;
      idx_nxt = 8'h00;
    end
    else if (link.rd_stop && state_r == D_RESP)
      state_nxt = D_READY;
  end

  // sequencer registers
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_r <= D_IDLE;
      code_r <= 8'h00;
      len_r <= 8'h00;
      param_r <= 8'h00;
      cnt_r <= 8'h00;
      idx_r <= 8'h00;
      rsp_len_r <= 8'h00;
      result_r <= 8'h00;
      rd_data_r <= 8'h00;
      rd_valid_r <= 1'b0;
      rd_ok_r <= 1'b0;
      class_r <= icm_pkg::ICM_CLS_NONE;
      exec_r <= 1'b0;
      brst_r <= 1'b0;
      spu_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      code_r <= code_nxt;
      len_r <= len_nxt;
      param_r <= param_nxt;
      cnt_r <= cnt_nxt;
      idx_r <= idx_nxt;
      rsp_len_r <= rsp_len_nxt;
      result_r <= result_nxt;
      rd_data_r <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
      rd_ok_r <= rd_ok_nxt;
      class_r <= class_nxt;
      exec_r <= exec_nxt;
      brst_r <= brst_nxt;
      spu_r <= spu_nxt;
    end
  end

  // staging buffer: memory stays untouched until the frame checks out
  always_ff @(posedge clk_sys_i)
  begin
    if (state_r == D_BODY && link.wr_valid && cnt_r != 8'h00 &&
        32'(cnt_r) <= icm_pkg::PAGE_BYTES)
      wbuf[5'(cnt_r - 8'h01)] <= link.wr_data;
  end

  // page store, no reset so contents model retained storage
  always_ff @(posedge clk_sys_i)
  begin
    if (commit)
      for (int i = 0; i < icm_pkg::PAGE_BYTES; i++)
        mem[8'(32'(page) * icm_pkg::PAGE_BYTES + i)] <= wbuf[i];
  end
endmodule
`default_nettype wire

// >>> tb/icm_link_props.sv
`timescale 1ns/100ps
`default_nettype none
module icm_link_props (
  input wire logic clk_sys_i, // system clock
  input wire logic rstn_i, // async reset, active low
  input wire logic wr_start, // write frame open
  input wire logic wr_valid, // write byte offered
  input wire logic wr_ready, // write byte accepted
  input wire logic [7:0] wr_data, // write byte
  input wire logic wr_stop, // write frame close
  input wire logic rd_start, // read frame open
  input wire logic rd_req, // read byte request
  input wire logic rd_valid, // read byte pulse
  input wire logic [7:0] rd_data, // read byte
  input wire logic rd_stop // read frame close
);
  logic [7:0] wcnt_r, wcnt_nxt, code_r, code_nxt, len_r, len_nxt;
  logic [7:0] par_r, par_nxt, rcnt_r, rcnt_nxt;
  logic open_r, open_nxt, wm, rm, pg_ok, full;
  // frame tracking; write count saturates so long frames stay invalid
  always_comb
  begin
    wcnt_nxt = wcnt_r;
    code_nxt = code_r;
    len_nxt = len_r;
    par_nxt = par_r;
    rcnt_nxt = rcnt_r;
    open_nxt = open_r;
    if (wr_valid && wr_ready)
    begin
      if (wcnt_r == 8'h00) code_nxt = wr_data;
      if (wcnt_r == 8'h01) len_nxt = wr_data;
      if (wcnt_r == 8'h02) par_nxt = wr_data;
      if (wcnt_r != 8'hFF) wcnt_nxt = wcnt_r + 8'h01;
    end
    if (wr_start) wcnt_nxt = 8'h00;
    if (rd_valid) rcnt_nxt = rcnt_r + 8'h01;
    if (rd_start) rcnt_nxt = 8'h00;
    if (rd_start) open_nxt = 1'b1;
    if (rd_stop || wr_start) open_nxt = 1'b0;
  end
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      {wcnt_r, code_r, len_r, par_r, rcnt_r} <= '0;
      open_r <= 1'b0;
    end
    else
    begin
      {wcnt_r, code_r, len_r, par_r} <= {wcnt_nxt, code_nxt, len_nxt, par_nxt};
      rcnt_r <= rcnt_nxt;
      open_r <= open_nxt;
    end
  end
  // decoded view of the last write frame
  assign wm = code_r == icm_pkg::CMD_WRITE_MEM;
  assign rm = code_r == icm_pkg::CMD_READ_MEM;
  assign pg_ok = par_r <= 8'h05;
  assign full = len_r == 8'h21 && wcnt_r == 8'h23; // code, len, param, 32 data

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  sequence s_len_byte; rd_valid && rcnt_r == 8'h00; endsequence
  sequence s_res_byte; rd_valid && rcnt_r == 8'h01; endsequence
  sequence s_any_body; rd_valid && rcnt_r != 8'h00; endsequence

  a_start_gives_ready: assert property (wr_start |=> wr_ready)
    else $error("no byte accepted after write start");
  a_stop_ends_write: assert property (wr_stop |=> !wr_ready)
    else $error("bytes still accepted after write stop");
  a_read_answers: assert property (open_r && rd_req |=> rd_valid)
    else $error("read request not answered in one cycle");
  a_no_stray_byte: assert property (rd_valid |-> $past(rd_req))
    else $error("read byte without request");
  a_length_first: assert property (s_len_byte |->
    rd_data == (rm ? 8'h21 : 8'h01))
    else $error("wrong length byte");
  a_result_legal: assert property (s_res_byte |->
    rd_data inside {8'hAA, 8'h55, 8'h77})
    else $error("result byte outside known codes");
  a_write_locked: assert property (s_res_byte ##0 (wm && full && pg_ok)
    |-> rd_data == (par_r[0] ? 8'h55 : 8'hAA))
    else $error("page write protection result wrong");
  a_write_invalid: assert property (s_res_byte ##0 (wm && !(full && pg_ok))
    |-> rd_data == 8'h77)
    else $error("invalid page write not refused");
  a_read_bad_fill: assert property (s_any_body ##0 (rm && !pg_ok)
    |-> rd_data == (rcnt_r == 8'h01 ? 8'h77 : 8'hFF))
    else $error("invalid page read not filled");
  a_read_good: assert property (s_res_byte ##0 (rm && pg_ok)
    |-> rd_data == 8'hAA)
    else $error("valid page read not successful");
endmodule
`default_nettype wire

// >>> tb/i2c_command_memory_front_end_tb.sv
`timescale 1ns/100ps
`default_nettype none
module i2c_command_memory_front_end_tb;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  logic dat_valid_i = 1'b0;
  logic [7:0] cmd_code_i = 8'h00, wr_len_i = 8'h00, param_i = 8'h00;
  logic [7:0] dat_i = 8'h00;
  logic cmd_ready_o, dat_ready_o, rsp_valid_o, done_o;
  logic [7:0] rsp_data_o, result_o, rsp_len_o, cmd_code_o;
  icm_pkg::icm_class_e cmd_class_o;
  logic cmd_exec_o, bus_reset_o, strong_pullup_o, busy_o;
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int rcnt;
  logic [7:0] wdat [32];
  logic [7:0] rdat [32];
  logic [7:0] mq [$];
  logic [7:0] ex_class, ex_code;
  logic ex_rst, ex_spu, ex_busy;

  always #10 clk_sys_i = ~clk_sys_i;
  icm_link_if link ();
  // short waits: the device answers at once, so the real times only slow runs
  icm_host #(.WRITE_WAIT_CYCLES(4), .READ_WAIT_CYCLES(4)) u_icm_host (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .link(link),
    .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
    .cmd_code_i(cmd_code_i), .wr_len_i(wr_len_i), .param_i(param_i),
    .dat_valid_i(dat_valid_i), .dat_i(dat_i), .dat_ready_o(dat_ready_o),
    .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .done_o(done_o),
    .result_o(result_o), .rsp_len_o(rsp_len_o));
  icm_dev u_icm_dev (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .link(link),
    .cmd_class_o(cmd_class_o), .cmd_code_o(cmd_code_o),
    .cmd_exec_o(cmd_exec_o), .bus_reset_o(bus_reset_o),
    .strong_pullup_o(strong_pullup_o), .busy_o(busy_o));
  icm_link_props u_icm_link_props (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .wr_start(link.wr_start), .wr_valid(link.wr_valid),
    .wr_ready(link.wr_ready), .wr_data(link.wr_data),
    .wr_stop(link.wr_stop), .rd_start(link.rd_start), .rd_req(link.rd_req),
    .rd_valid(link.rd_valid), .rd_data(link.rd_data),
    .rd_stop(link.rd_stop));

  // registered pulses, so the falling edge sees them settled
  always @(negedge clk_sys_i)
  begin
    if (cmd_exec_o === 1'b1)
    begin
      ex_class = 8'(cmd_class_o);
      ex_code = cmd_code_o;
      ex_rst = bus_reset_o;
      ex_spu = strong_pullup_o;
    end
    if (link.wr_stop === 1'b1) ex_busy = busy_o;
    if (link.rd_start === 1'b1) mq.delete();
    if (link.rd_valid === 1'b1) mq.push_back(link.rd_data);
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // a hang anywhere ends here with a mismatch counted
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic check(input string nm, input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one full command: write frame, wait, read-back, collected at negedge
  task automatic run(input logic [7:0] code, len, par, input int n);
    int i, k;
    i = 0;
    k = 0;
    {ex_class, ex_code, ex_rst, ex_spu} = '1;
    ex_busy = 1'b0;
    cmd_valid_i = 1'b1;
    {cmd_code_i, wr_len_i, param_i} = {code, len, par};
    #1;
    while (cmd_ready_o !== 1'b1 && k < 100)
    begin
      @(negedge clk_sys_i);
      k++;
    end
    @(negedge clk_sys_i);
    cmd_valid_i = 1'b0;
    while (i < n && k < 400)
    begin
      dat_valid_i = 1'b1;
      dat_i = wdat[i];
      #1;
      if (dat_ready_o === 1'b1) i++;
      @(negedge clk_sys_i);
      k++;
    end
    dat_valid_i = 1'b0;
    rcnt = 0;
    while (done_o !== 1'b1 && k < 2000)
    begin
      // count every byte so an overlong reply still shows up
      if (rsp_valid_o === 1'b1)
      begin
        if (rcnt < 32) rdat[rcnt] = rsp_data_o;
        rcnt++;
      end
      @(negedge clk_sys_i);
      k++;
    end
    check("done", 8'(done_o), 8'h01);
    check("exec code", ex_code, code);
    check("busy in frame", 8'(ex_busy), 8'h01);
    check("idle after", 8'(busy_o), 8'h00);
  endtask

  task automatic rsp(input logic [7:0] len, res, cls);
    check("length", rsp_len_o, len);
    check("result", result_o, res);
    check("wire length", mq[0], len);
    check("wire result", mq[1], res);
    check("class", ex_class, cls);
  endtask

  task automatic wr_page(input logic [7:0] par, mult, res);
    for (int i = 0; i < 32; i++) wdat[i] = 8'(i * mult + 3);
    run(icm_pkg::CMD_WRITE_MEM, 8'h21, par, 32);
    rsp(8'h01, res, 8'(icm_pkg::ICM_CLS_MEMORY));
    check("write reply data", 8'(rcnt), 8'h00);
  endtask

  // mode 0 compares the pattern, 1 expects fill, 2 skips the data
  task automatic rd_page(input logic [7:0] par, mult, res, input int mode);
    run(icm_pkg::CMD_READ_MEM, 8'h01, par, 0);
    rsp(8'h21, res, 8'(icm_pkg::ICM_CLS_MEMORY));
    check("data count", 8'(rcnt), 8'h20);
    for (int i = 0; i < 32 && mode < 2; i++)
      check("data", rdat[i], mode ? 8'hFF : 8'(i * mult + 3));
  endtask

  task automatic t_pages;
    wr_page(8'h00, 8'h05, 8'hAA);
    wr_page(8'h02, 8'h09, 8'hAA);
    wr_page(8'h04, 8'h0B, 8'hAA);
    rd_page(8'h00, 8'h05, 8'hAA, 0);
    rd_page(8'h04, 8'h0B, 8'hAA, 0);
  endtask

  task automatic t_refusals;
    wr_page(8'h01, 8'h07, 8'h55);
    wr_page(8'h05, 8'h07, 8'h55);
    wr_page(8'h08, 8'h07, 8'h77);
    wr_page(8'h06, 8'h07, 8'h77);
    run(icm_pkg::CMD_WRITE_MEM, 8'h01, 8'h02, 0);
    rsp(8'h01, 8'h77, 8'(icm_pkg::ICM_CLS_MEMORY));
    rd_page(8'h02, 8'h09, 8'hAA, 0);
    rd_page(8'h00, 8'h05, 8'hAA, 0);
    rd_page(8'h06, 8'h00, 8'h77, 1);
    rd_page(8'h0A, 8'h00, 8'h77, 1);
    rd_page(8'h03, 8'h00, 8'hAA, 2);
  endtask

  // every other code, in table order: memory, config, bus, crc
  task automatic t_codes;
    logic [7:0] cd [13] = '{8'hC3, 8'hAA, 8'h75, 8'h52, 8'h99, 8'h62,
      8'h88, 8'hAB, 8'h50, 8'h68, 8'h11, 8'h57, 8'hCC};
    logic [7:0] cls;
    logic blk;
    for (int i = 0; i < 13; i++)
    begin
      cls = i < 2 ? 8'(icm_pkg::ICM_CLS_MEMORY) : i < 6 ?
        8'(icm_pkg::ICM_CLS_CONFIG) : i < 12 ? 8'(icm_pkg::ICM_CLS_BUS) :
        8'(icm_pkg::ICM_CLS_CRC);
      blk = cd[i] == 8'hAB || cd[i] == 8'h68;
      run(cd[i], 8'h01, 8'h03, 0);
      rsp(8'h01, blk ? 8'hAA : 8'h77, cls);
      check("bus reset", 8'(ex_rst), 8'(blk));
      check("pullup", 8'(ex_spu), 8'(blk));
    end
    run(8'hAB, 8'h01, 8'h00, 0);
    check("no reset", 8'(ex_rst), 8'h00);
    check("no pullup", 8'(ex_spu), 8'h00);
  endtask

  initial
  begin
    repeat (5) @(negedge clk_sys_i);
    rstn_i = 1'b1;
    t_pages();
    t_refusals();
    t_codes();
    end_of_test();
  end
endmodule
`default_nettype wire
